// ==== verilog/cid_core.sv ====
/*
 * Instruction decode and execute core for an 8-bit CPU subset: sum,
 * sum-with-carry, conjunction, shifts, index and stack adjust, carry
 * branch, compare-and-branch and memory transfer, with sum, conjunction and
 * shifts over all their addressing modes, compare-and-branch and transfer in
 * post-increment modes only. Assumes a 64 Kbyte memory whose read data is valid
 * in the same cycle as the address; one bus cycle per clock.
 */
// Summary of operation
// - Flags hold overflow at bit 7, half carry 4, mask 3, negative 2, zero 1, carry 0.
// - Carry takes the carry out of bit 7 of a sum.
// - Zero-page address is the operand byte with a zero high byte.
// - A 16-bit memory value has its high byte at the address and low byte one above.
// - Branch target is the next instruction address plus the signed offset byte.
// - Index and stack byte offsets are zero-extended before the add.
// - Full-address mode takes high then low address byte from the stream.
// - Post-increment without offset decodes only for compare-branch and transfer.
// - Byte offset with post-increment decodes only for compare-branch.
// - Indexed address is the index pair plus none, a byte or a word offset.
// - Stack-relative address is stack pointer plus byte or word offset, behind a prefix.
// - A word offset is fetched upper byte first.
// - Index adjust sign-extends its byte, keeps flags and takes 2 cycles.
// - Carry-clear branch jumps when carry is 0, keeps flags and takes 3 cycles.
// - After the operand fetch in byte-offset post-increment mode the index pair steps by one.
`timescale 1ns/100ps
`include "cid_defs.svh"

module cid_core (
	input  wire logic          core_clk,
	input  wire logic          nrst,
	input  wire logic [7:0]    mem_rdata,
	output cid_pkg::cid_bus_t  bus_o,
	output cid_pkg::cid_regs_t regs_o,
	output logic               illegal_op
);
	import cid_pkg::*;

	// ==========================================================
	// Decode
	function automatic cid_dec_t decode(input logic pre, input logic [7:0] opc);
		cid_dec_t   d;
		logic [3:0] hn;
		logic [3:0] ln;
		hn = opc[7:4];
		ln = opc[3:0];
		d.op = OP_ILL;
		d.mode = no_operand_a_mode;
		if (pre) begin
			if (hn == `CID_HN_IX2 || hn == `CID_HN_IX1) begin
				d.mode = (hn == `CID_HN_IX2) ? stack_word_offset_mode : stack_byte_offset_mode;
				if (ln == `CID_LN_ADC) d.op = OP_ADC;
				else if (ln == `CID_LN_ADD) d.op = OP_ADD;
				else if (ln == `CID_LN_AND) d.op = OP_AND;
			end else if (hn == `CID_HS_IX1) begin
				d.mode = stack_byte_offset_mode;
				if (ln == `CID_LN_ASL) d.op = OP_ASL;
				else if (ln == `CID_LN_ASR) d.op = OP_ASR;
			end
		end else if (opc == `CID_OP_AIX) begin
			d.op = OP_AIX;
			d.mode = literal_operand_mode;
		end else if (opc == `CID_OP_AIS) begin
			d.op = OP_AIS;
			d.mode = literal_operand_mode;
		end else if (opc == `CID_OP_BCC) begin
			d.op = OP_BCC;
			d.mode = relative_mode;
		end else if (opc == `CID_OP_COMPARE_BRANCH_IF_EQUAL_IXP || opc == `CID_OP_MOV_IXP) begin
			d.op = (opc == `CID_OP_MOV_IXP) ? OP_MOV : OP_COMPARE_BRANCH_IF_EQUAL;
			d.mode = index_postinc_mode;
		end else if (opc == `CID_OP_COMPARE_BRANCH_IF_EQUAL_IX1P) begin
			d.op = OP_COMPARE_BRANCH_IF_EQUAL;
			d.mode = index_byte_offset_postinc_mode;
		end else if (hn >= `CID_HN_IMM) begin
			unique case (hn)
				`CID_HN_IMM: d.mode = literal_operand_mode;
				`CID_HN_DIR: d.mode = zero_page_mode;
				`CID_HN_EXT: d.mode = full_address_mode;
				`CID_HN_IX2: d.mode = index_word_offset_mode;
				`CID_HN_IX1: d.mode = index_byte_offset_mode;
				default:     d.mode = index_no_offset_mode;
			endcase
			if (ln == `CID_LN_ADC) d.op = OP_ADC;
			else if (ln == `CID_LN_ADD) d.op = OP_ADD;
			else if (ln == `CID_LN_AND) d.op = OP_AND;
		end else if (hn >= `CID_HS_DIR && hn <= `CID_HS_IX) begin
			unique case (hn)
				`CID_HS_DIR:  d.mode = zero_page_mode;
				`CID_HS_INHA: d.mode = no_operand_a_mode;
				`CID_HS_INHX: d.mode = no_operand_x_mode;
				`CID_HS_IX1:  d.mode = index_byte_offset_mode;
				default:      d.mode = index_no_offset_mode;
			endcase
			if (ln == `CID_LN_ASL) d.op = OP_ASL;
			else if (ln == `CID_LN_ASR) d.op = OP_ASR;
		end
		return d;
	endfunction : decode

	// Operand bytes following the opcode
	function automatic logic [1:0] nbytes(input cid_mode_t m);
		unique case (m)
			full_address_mode, index_word_offset_mode,
			stack_word_offset_mode, index_byte_offset_postinc_mode: nbytes = 2'd2;
			index_no_offset_mode, no_operand_a_mode, no_operand_x_mode: nbytes = 2'd0;
			default: nbytes = 2'd1;
		endcase
	endfunction : nbytes

	// ==========================================================
	// Arithmetic unit
	function automatic cid_alu_t alu(input cid_op_t op, input logic [7:0] a,
			input logic [7:0] m, input cid_flags_t f);
		cid_alu_t   r;
		logic [8:0] s;
		logic [4:0] hs;
		logic       cin;
		cin = (op == OP_ADC) ? f.c : 1'b0;
		s = {1'b0, a} + {1'b0, m} + {8'h00, cin};
		hs = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
		r.flags = f;
		r.res = a;
		case (op)
			OP_ADD, OP_ADC: begin
				r.res = s[7:0];
				r.flags.v = (a[7] & m[7] & ~s[7]) | (~a[7] & ~m[7] & s[7]);
				r.flags.h = hs[4];
				r.flags.c = s[8];
			end
			OP_AND: begin
				r.res = a & m;
				r.flags.v = 1'b0;
			end
			OP_ASL: begin
				r.res = {m[6:0], 1'b0};
				r.flags.c = m[7];
				r.flags.v = m[6] ^ m[7];
			end
			OP_ASR: begin
				r.res = {m[7], m[7:1]};
				r.flags.c = m[0];
				r.flags.v = m[7] ^ m[0];
			end
			default: ;
		endcase
		if (op == OP_ADD || op == OP_ADC || op == OP_AND || op == OP_ASL || op == OP_ASR) begin
			r.flags.n = r.res[7];
			r.flags.z = (r.res == 8'h00);
		end
		return r;
	endfunction : alu

	// ==========================================================
	// State
	cid_state_t  state_q, state_d;
	cid_dec_t    dec_q, dec_d, dec_w;
	cid_flags_t  ccr_q, ccr_d;
	cid_alu_t    ex;
	logic        pre_q, pre_d;
	logic [1:0]  cnt_q, cnt_d;
	logic [15:0] opr_q, opr_d;
	logic [15:0] pc_q, pc_d;
	logic [15:0] hx_q, hx_d;
	logic [15:0] sp_q, sp_d;
	logic [7:0]  a_q, a_d;
	logic [7:0]  wdata_q, wdata_d;
	logic [15:0] wa_q, wa_d;
	logic [15:0] ea;
	logic [15:0] rel_w;
	logic [7:0]  m_sel;
	logic        imm_done;

	assign dec_w = decode(pre_q, mem_rdata);
	assign imm_done = (state_q == ST_OPR) && (cnt_q == 2'd1) && (dec_q.mode == literal_operand_mode);
	assign rel_w = {{8{opr_q[7]}}, opr_q[7:0]};
	assign m_sel = (state_q == ST_OPR) ? mem_rdata :
		(dec_q.mode == no_operand_a_mode) ? a_q :
		(dec_q.mode == no_operand_x_mode) ? hx_q[7:0] : mem_rdata;
	assign ex = alu(dec_q.op, a_q, m_sel, ccr_q);

	// Effective address
	always_comb begin
		unique case (dec_q.mode)
			zero_page_mode:                 ea = {`CID_ZP_HI, opr_q[7:0]};
			full_address_mode:              ea = opr_q;
			index_word_offset_mode:         ea = hx_q + opr_q;
			index_byte_offset_mode:         ea = hx_q + {8'h00, opr_q[7:0]};
			index_byte_offset_postinc_mode: ea = hx_q + {8'h00, opr_q[15:8]};
			stack_word_offset_mode:         ea = sp_q + opr_q;
			stack_byte_offset_mode:         ea = sp_q + {8'h00, opr_q[7:0]};
			default:                        ea = hx_q;
		endcase
	end

	// ==========================================================
	// Sequencer
	always_comb begin
		state_d = state_q;
		dec_d = dec_q;
		ccr_d = ccr_q;
		pre_d = pre_q;
		cnt_d = cnt_q;
		opr_d = opr_q;
		pc_d = pc_q;
		hx_d = hx_q;
		sp_d = sp_q;
		a_d = a_q;
		wdata_d = wdata_q;
		wa_d = wa_q;
		bus_o = '0;
		bus_o.addr = pc_q;
		bus_o.wdata = wdata_q;
		illegal_op = 1'b0;
		unique case (state_q)
			ST_VECH: begin
				bus_o.addr = `CID_VEC_ADDR;
				bus_o.rd = 1'b1;
				pc_d[15:8] = mem_rdata;
				state_d = ST_VECL;
			end
			ST_VECL: begin
				bus_o.addr = `CID_VEC_ADDR + `CID_VEC_STEP;
				bus_o.rd = 1'b1;
				pc_d[7:0] = mem_rdata;
				state_d = ST_FETCH;
			end
			ST_FETCH: begin
				bus_o.rd = 1'b1;
				pc_d = pc_q + `CID_PTR_STEP;
				opr_d = 16'h0000;
				if (mem_rdata == `CID_PREFIX && !pre_q) begin
					pre_d = 1'b1;
				end else begin
					pre_d = 1'b0;
					dec_d = dec_w;
					cnt_d = nbytes(dec_w.mode);
					if (dec_w.op == OP_ILL) illegal_op = 1'b1;
					else if (nbytes(dec_w.mode) != 2'd0) state_d = ST_OPR;
					else state_d = ST_EXEC;
				end
			end
			ST_OPR: begin
				bus_o.rd = 1'b1;
				pc_d = pc_q + `CID_PTR_STEP;
				opr_d = {opr_q[7:0], mem_rdata};
				cnt_d = cnt_q - 2'd1;
				if (cnt_q == 2'd1) state_d = imm_done ? ST_FETCH : ST_EXEC;
				if (imm_done) begin
					if (dec_q.op == OP_AIX) hx_d = hx_q + {{8{mem_rdata[7]}}, mem_rdata};
					else if (dec_q.op == OP_AIS) sp_d = sp_q + {{8{mem_rdata[7]}}, mem_rdata};
					else begin
						a_d = ex.res;
						ccr_d = ex.flags;
					end
				end
			end
			ST_EXEC: begin
				bus_o.addr = ea;
				bus_o.rd = (dec_q.mode != no_operand_a_mode) && (dec_q.mode != no_operand_x_mode) &&
					(dec_q.mode != relative_mode);
				state_d = ST_FETCH;
				case (dec_q.op)
					OP_ADD, OP_ADC, OP_AND: begin
						a_d = ex.res;
						ccr_d = ex.flags;
					end
					OP_ASL, OP_ASR: begin
						ccr_d = ex.flags;
						if (dec_q.mode == no_operand_a_mode) a_d = ex.res;
						else if (dec_q.mode == no_operand_x_mode) hx_d[7:0] = ex.res;
						else begin
							wdata_d = ex.res;
							wa_d = ea;
							state_d = ST_WRB;
						end
					end
					OP_BCC: if (!ccr_q.c) pc_d = pc_q + rel_w;
					OP_COMPARE_BRANCH_IF_EQUAL: begin
						hx_d = hx_q + `CID_PTR_STEP;
						if (mem_rdata == a_q) pc_d = pc_q + rel_w;
					end
					OP_MOV: begin
						hx_d = hx_q + `CID_PTR_STEP;
						wdata_d = mem_rdata;
						wa_d = {`CID_ZP_HI, opr_q[7:0]};
						state_d = ST_WRB;
					end
					default: ;
				endcase
			end
			ST_WRB: begin
				bus_o.addr = wa_q;
				bus_o.wr = 1'b1;
				state_d = ST_FETCH;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_q <= ST_VECH;
			dec_q <= '{op: OP_ILL, mode: no_operand_a_mode};
			ccr_q <= `CID_CCR_RST;
			pre_q <= 1'b0;
			cnt_q <= 2'd0;
			opr_q <= 16'h0000;
			pc_q <= 16'h0000;
			hx_q <= `CID_HX_RST;
			sp_q <= `CID_SP_RST;
			a_q <= `CID_A_RST;
			wdata_q <= 8'h00;
			wa_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			dec_q <= dec_d;
			ccr_q <= ccr_d;
			pre_q <= pre_d;
			cnt_q <= cnt_d;
			opr_q <= opr_d;
			pc_q <= pc_d;
			hx_q <= hx_d;
			sp_q <= sp_d;
			a_q <= a_d;
			wdata_q <= wdata_d;
			wa_q <= wa_d;
		end
	end

	assign regs_o = '{acc: a_q, hx: hx_q, stack_ptr: sp_q, program_counter: pc_q, condition_flags_reg: ccr_q};

	// ==========================================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	logic [8:0] chk_sum;
	logic       alu_go;
	assign chk_sum = {1'b0, a_q} + {1'b0, m_sel};
	assign alu_go = imm_done || (state_q == ST_EXEC);

	and_clears_v_a: assert property (alu_go && dec_q.op == OP_AND |=> !ccr_q.v && ccr_q.z == (a_q == 8'h00))
		else $error("conjunction left overflow set or zero wrong");
	carry_out_a: assert property (alu_go && dec_q.op == OP_ADD |=> ccr_q.c == $past(chk_sum[8]))
		else $error("carry not taken from bit 7 carry out");
	zero_page_a: assert property (state_q == ST_EXEC && dec_q.mode == zero_page_mode |->
		bus_o.addr == {8'h00, opr_q[7:0]})
		else $error("zero-page address high byte not zero");
	vector_order_a: assert property (state_q == ST_VECH |-> bus_o.addr == 16'hfffe ##1
		(state_q == ST_VECL && bus_o.addr == 16'hffff && pc_q[15:8] == $past(mem_rdata)))
		else $error("vector bytes not read high then low");
	bcc_target_a: assert property (state_q == ST_EXEC && dec_q.op == OP_BCC && !ccr_q.c |=>
		pc_q == $past(pc_q) + {{8{$past(opr_q[7])}}, $past(opr_q[7:0])})
		else $error("branch target wrong");
	stack_offset_a: assert property (state_q == ST_EXEC && dec_q.mode == stack_byte_offset_mode |->
		bus_o.addr == sp_q + {8'h00, opr_q[7:0]})
		else $error("stack byte offset not zero-extended");
	postinc_only_a: assert property (state_q == ST_FETCH && (dec_w.mode == index_postinc_mode ||
		dec_w.mode == index_byte_offset_postinc_mode) |-> dec_w.op inside {OP_COMPARE_BRANCH_IF_EQUAL, OP_MOV})
		else $error("post-increment mode on wrong operation");
	ix1p_compare_branch_if_equal_a: assert property (state_q == ST_FETCH && dec_w.mode == index_byte_offset_postinc_mode |->
		dec_w.op == OP_COMPARE_BRANCH_IF_EQUAL)
		else $error("byte offset post-increment not compare-branch");
	index_step_a: assert property (state_q == ST_EXEC && dec_q.op == OP_COMPARE_BRANCH_IF_EQUAL |=> hx_q == $past(hx_q) + 16'h0001)
		else $error("index pair not stepped after operand");
	word_order_a: assert property (state_q == ST_OPR && cnt_q == 2'd2 |=>
		opr_q[7:0] == $past(mem_rdata) ##1 opr_q[15:8] == $past(opr_q[7:0], 1))
		else $error("word operand byte order wrong");
	aix_cycles_a: assert property (state_q == ST_FETCH && !pre_q && mem_rdata == 8'haf |=>
		state_q == ST_OPR ##1 (state_q == ST_FETCH && ccr_q == $past(ccr_q) &&
		hx_q == $past(hx_q) + {{8{$past(mem_rdata[7])}}, $past(mem_rdata)}))
		else $error("index adjust wrong result or timing");
	bcc_cycles_a: assert property (state_q == ST_FETCH && !pre_q && mem_rdata == 8'h24 |=>
		state_q == ST_OPR ##1 state_q == ST_EXEC ##1 (state_q == ST_FETCH && ccr_q == $past(ccr_q, 2)))
		else $error("carry-clear branch not 3 cycles or flags changed");

	bcc_taken_c: cover property (state_q == ST_EXEC && dec_q.op == OP_BCC && !ccr_q.c);
	compare_branch_if_equal_hit_c: cover property (state_q == ST_EXEC && dec_q.op == OP_COMPARE_BRANCH_IF_EQUAL && mem_rdata == a_q);
	shift_wrb_c: cover property (state_q == ST_WRB && dec_q.op == OP_ASL);
	stack_word_c: cover property (state_q == ST_EXEC && dec_q.mode == stack_word_offset_mode);

endmodule : cid_core

// ==== pkg/cid_defs.svh ====
/*
 * Constants of the instruction decode core: vector address, opcode codes,
 * opcode nibble groups, reset values and address arithmetic constants.
 * Assumes inclusion by bare name from design files.
 */
`ifndef CID_DEFS_SVH
`define CID_DEFS_SVH

// ==========================================================
// Start vector, reset values and address constants
`define CID_VEC_ADDR     16'hfffe
`define CID_VEC_STEP     16'h0001
`define CID_SP_RST       16'h00ff
`define CID_HX_RST       16'h0000
`define CID_A_RST        8'h00
`define CID_CCR_RST      8'h08
`define CID_ZP_HI        8'h00
`define CID_PTR_STEP     16'h0001

// ==========================================================
// Whole opcodes
`define CID_PREFIX       8'h9e
`define CID_OP_AIX       8'haf
`define CID_OP_AIS       8'ha7
`define CID_OP_BCC       8'h24
`define CID_OP_COMPARE_BRANCH_IF_EQUAL_IXP  8'h71
`define CID_OP_COMPARE_BRANCH_IF_EQUAL_IX1P 8'h61
`define CID_OP_MOV_IXP   8'h7e

// ==========================================================
// Low nibble: operation
`define CID_LN_ADC       4'h9
`define CID_LN_ADD       4'hb
`define CID_LN_AND       4'h4
`define CID_LN_ASL       4'h8
`define CID_LN_ASR       4'h7

// ==========================================================
// High nibble: operand form of arithmetic group
`define CID_HN_IMM       4'ha
`define CID_HN_DIR       4'hb
`define CID_HN_EXT       4'hc
`define CID_HN_IX2       4'hd
`define CID_HN_IX1       4'he
`define CID_HN_IX        4'hf

// ==========================================================
// High nibble: operand form of shift group
`define CID_HS_DIR       4'h3
`define CID_HS_INHA      4'h4
`define CID_HS_INHX      4'h5
`define CID_HS_IX1       4'h6
`define CID_HS_IX        4'h7

`endif

// ==== pkg/cid_pkg.sv ====
/*
 * Types of the instruction decode core: flags layout, operations,
 * operand modes, sequencer states and port bundles.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cid_pkg;

	// ==========================================================
	// Condition flags, bit 7 down to bit 0
	typedef struct packed {
		logic       v;
		logic [1:0] rsvd;
		logic       h;
		logic       i;
		logic       n;
		logic       z;
		logic       c;
	} cid_flags_t;

	typedef enum logic [3:0] {
		OP_ADD, OP_ADC, OP_AND, OP_ASL, OP_ASR, OP_AIX,
		OP_AIS, OP_BCC, OP_COMPARE_BRANCH_IF_EQUAL, OP_MOV, OP_ILL
	} cid_op_t;

	typedef enum logic [3:0] {
		literal_operand_mode, zero_page_mode, full_address_mode,
		index_no_offset_mode, index_postinc_mode, index_byte_offset_mode,
		index_byte_offset_postinc_mode, index_word_offset_mode,
		stack_byte_offset_mode, stack_word_offset_mode, relative_mode,
		no_operand_a_mode, no_operand_x_mode
	} cid_mode_t;

	typedef enum logic [5:0] {
		ST_VECH = 6'b000001,
		ST_VECL = 6'b000010,
		ST_FETCH = 6'b000100,
		ST_OPR = 6'b001000,
		ST_EXEC = 6'b010000,
		ST_WRB = 6'b100000
	} cid_state_t;

	typedef struct packed {
		cid_op_t   op;
		cid_mode_t mode;
	} cid_dec_t;

	typedef struct packed {
		logic [7:0] res;
		cid_flags_t flags;
	} cid_alu_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr;
		logic [7:0]  wdata;
	} cid_bus_t;

	typedef struct packed {
		logic [7:0]  acc;
		logic [15:0] hx;
		logic [15:0] stack_ptr;
		logic [15:0] program_counter;
		cid_flags_t  condition_flags_reg;
	} cid_regs_t;

endpackage : cid_pkg

// ==== verification/cid_mem_model.sv ====
/*
 * Memory partner of the decode core: 64 Kbyte array, read data answered in
 * the same cycle as the address, write taken on the rising edge.
 * Assumes the bench preloads the array through hierarchical access.
 */
`timescale 1ns/100ps

module cid_mem_model (
	input  wire logic         core_clk,
	input  cid_pkg::cid_bus_t bus,
	output logic [7:0]        rdata
);
	import cid_pkg::*;

	logic [7:0] mem [0:65535];
	logic [7:0] last_q;

	// ==========================================================
	// Storage
	initial begin
		last_q = 8'h00;
		for (int k = 0; k < 65536; k++) begin
			mem[k] = 8'h9d;
		end
	end

	// Word values sit high byte at the address, low byte one above
	always @(posedge core_clk) begin
		if (bus.wr) begin
			mem[bus.addr] <= bus.wdata;
		end
		if (bus.rd) begin
			last_q <= mem[bus.addr];
		end
	end

	// ==========================================================
	// Read port
	// Undriven bus shows the inverse of the last value, never a stale copy
	assign rdata = bus.rd ? mem[bus.addr] : ~last_q;

endmodule : cid_mem_model

// ==== verification/cid_core_bench.sv ====
/*
 * Self-checking bench of the decode core: reset, arithmetic flags,
 * addressing modes, carry branch and post-increment forms.
 * Assumes the memory model of cid_mem_model on the core bus.
 */
`timescale 1ns/100ps

`define CHK(what, exp, got) \
	begin \
		checked++; \
		if ((got) !== (exp)) begin \
			n_fail++; \
			$display("ERROR %s expected %h seen %h", what, exp, got); \
		end \
	end

module cid_core_bench;
	import cid_pkg::*;

	logic       core_clk;
	logic       nrst;
	logic [7:0] mem_rdata;
	cid_bus_t   bus;
	cid_regs_t  regs;
	logic       illegal_op;
	logic [7:0] prog[$];
	int         n_fail;
	int         checked;

	cid_core u_cid_core (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.mem_rdata  (mem_rdata),
		.bus_o      (bus),
		.regs_o     (regs),
		.illegal_op (illegal_op)
	);

	cid_mem_model u_cid_mem_model (
		.core_clk (core_clk),
		.bus      (bus),
		.rdata    (mem_rdata)
	);

	always #2 core_clk = ~core_clk;

	// ==========================================================
	// Helpers
	task automatic put(input logic [15:0] a);
		foreach (prog[k]) begin
			u_cid_mem_model.mem[a + 16'(k)] = prog[k];
		end
	endtask : put

	task automatic poke(input logic [15:0] a, input logic [7:0] d);
		u_cid_mem_model.mem[a] = d;
	endtask : poke

	task automatic run(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : run

	task automatic boot(input logic [15:0] start);
		poke(16'hfffe, start[15:8]);
		poke(16'hffff, start[7:0]);
		nrst = 1'b0;
		run(6);
		nrst = 1'b1;
		run(2);
	endtask : boot

	task automatic stop_test;
		if (n_fail == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		prog = '{8'hab, 8'h05};
		put(16'h1000);
		boot(16'h1000);
		`CHK("flags", 8'h08, regs.condition_flags_reg)
		`CHK("stack", 16'h00ff, regs.stack_ptr)
		`CHK("index", 16'h0000, regs.hx)
		`CHK("pc", 16'h1000, regs.program_counter)
		`CHK("illegal", 1'b0, illegal_op)
		run(2);
		`CHK("acc", 8'h05, regs.acc)
		`CHK("illegal", 1'b1, illegal_op)
		run(1);
		`CHK("pc", 16'h1003, regs.program_counter)
		// Reset in mid-run
		nrst = 1'b0;
		run(1);
		`CHK("addr", 16'hfffe, bus.addr)
		`CHK("rd", 1'b1, bus.rd)
		`CHK("acc", 8'h00, regs.acc)
	endtask : t_reset

	task automatic t_arith;
		logic [7:0] acc_e[4] = '{8'hff, 8'h00, 8'h80, 8'h80};
		logic [7:0] flg_e[4] = '{8'h0c, 8'h1b, 8'h9c, 8'h1c};
		prog = '{8'hab, 8'hff, 8'hab, 8'h01, 8'ha9, 8'h7f, 8'ha4, 8'hc0};
		put(16'h1100);
		boot(16'h1100);
		for (int k = 0; k < 4; k++) begin
			run(2);
			`CHK("acc", acc_e[k], regs.acc)
			`CHK("flags", flg_e[k], regs.condition_flags_reg)
		end
	endtask : t_arith

	task automatic t_modes;
		int         cyc[8] = '{3, 4, 2, 3, 4, 2, 4, 5};
		logic [7:0] acc_e[8] = '{8'h05, 8'h15, 8'h15, 8'h16, 8'h18, 8'h1c, 8'h24, 8'h44};
		prog = '{8'hbb, 8'h40, 8'hcb, 8'h12, 8'h34, 8'haf, 8'h80, 8'heb, 8'h90, 8'hdb, 8'h01, 8'h00,
			8'hfb, 8'h9e, 8'heb, 8'h81, 8'h9e, 8'hdb, 8'h00, 8'h02};
		put(16'h1200);
		poke(16'h0040, 8'h05);
		poke(16'h1234, 8'h10);
		poke(16'h0010, 8'h01);
		poke(16'h0080, 8'h02);
		poke(16'hff80, 8'h04);
		poke(16'h0180, 8'h08);
		poke(16'h0101, 8'h20);
		boot(16'h1200);
		for (int k = 0; k < 8; k++) begin
			run(cyc[k]);
			`CHK("acc", acc_e[k], regs.acc)
		end
		`CHK("index", 16'hff80, regs.hx)
		`CHK("flags", 8'h08, regs.condition_flags_reg)
	endtask : t_modes

	task automatic t_branch;
		prog = '{8'h24, 8'h10};
		put(16'h2000);
		prog = '{8'h24, 8'h80};
		put(16'h2012);
		prog = '{8'hab, 8'hff, 8'hab, 8'h01, 8'h24, 8'h05};
		put(16'h1f94);
		boot(16'h2000);
		run(3);
		`CHK("pc", 16'h2012, regs.program_counter)
		`CHK("flags", 8'h08, regs.condition_flags_reg)
		run(3);
		`CHK("pc", 16'h1f94, regs.program_counter)
		run(4);
		run(3);
		`CHK("pc", 16'h1f9a, regs.program_counter)
		`CHK("flags", 8'h1b, regs.condition_flags_reg)
	endtask : t_branch

	task automatic t_post;
		prog = '{8'haf, 8'h30, 8'h71, 8'h04};
		put(16'h3000);
		prog = '{8'h61, 8'h02, 8'h05};
		put(16'h3008);
		prog = '{8'h7e, 8'h50};
		put(16'h3010);
		poke(16'h0030, 8'h00);
		poke(16'h0032, 8'h5a);
		poke(16'h0033, 8'h00);
		boot(16'h3000);
		run(2);
		`CHK("index", 16'h0030, regs.hx)
		run(3);
		`CHK("pc", 16'h3008, regs.program_counter)
		`CHK("index", 16'h0031, regs.hx)
		run(4);
		`CHK("pc", 16'h3010, regs.program_counter)
		`CHK("index", 16'h0032, regs.hx)
		run(4);
		`CHK("moved", 8'h5a, u_cid_mem_model.mem[16'h0050])
		`CHK("index", 16'h0033, regs.hx)
		`CHK("pc", 16'h3012, regs.program_counter)
	endtask : t_post

	// ==========================================================
	// Sequence and watchdog
	initial begin
		core_clk = 1'b0;
		nrst = 1'b0;
		n_fail = 0;
		checked = 0;
		// Let the memory fill settle before preloading
		#1;
		t_reset;
		t_arith;
		t_modes;
		t_branch;
		t_post;
		stop_test;
	end

	initial begin
		#4000;
		n_fail++;
		stop_test;
	end

endmodule : cid_core_bench
